// ==== pmj_panel.sv ====
`timescale 1ns/1ns
module pmj_panel
    import pmj_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              key_mode,
    input  wire logic              key_up,
    input  wire logic              key_down,
    input  wire logic              key_shift,
    input  wire logic              key_set,
    input  wire logic [MON_W-1:0]  monitor_a,
    input  wire logic [MON_W-1:0]  monitor_b,
    input  wire logic [12:0]       jog_speed_param,
    input  wire logic [7:0]        control_mode_param,
    input  wire logic              forward_drive_inhibit,
    input  wire logic              reverse_drive_inhibit,
    output logic [HALF_W-1:0]      disp_value,
    output logic [3:0]             disp_dp,
    output pmj_show_type           disp_kind,
    output logic [7:0]             disp_number,
    output logic                   jog_active,
    output logic                   servo_on,
    output logic signed [13:0]     speed_cmd,
    output logic                   position_mode,
    output logic                   fwd_inhibit_eff,
    output logic                   rev_inhibit_eff
);
    // ==========================================================
    // key edges
    logic [4:0] keys_d;
    wire  [4:0] keys_now = {key_mode, key_up, key_down, key_shift, key_set};
    wire  [4:0] press    = keys_now & ~keys_d;
    wire        p_mode   = press[4];
    wire        p_up     = press[3];
    wire        p_down   = press[2];
    wire        p_shift  = press[1];
    wire        p_set    = press[0];
    wire        long_mode;

    pmj_hold_timer #(.HOLD_COUNT(HOLD_COUNT)) u_hold (
        .clk        (clk),
        .rst        (rst),
        .key_level  (key_mode),
        .long_press (long_mode)
    );

    function automatic logic [HALF_W-1:0] half_of(input logic [MON_W-1:0] w, input logic hi);
        half_of = hi ? w[MON_W-1:HALF_W] : w[HALF_W-1:0];
    endfunction

    function automatic logic [12:0] clamp_speed(input logic [12:0] s);
        clamp_speed = (s > JOG_SPEED_MAX) ? JOG_SPEED_MAX : s;
    endfunction

    // ==========================================================
    // panel state machine
    pmj_state_type state;
    pmj_state_type next_state;
    logic [7:0]    aux_num;
    logic [7:0]    next_aux_num;
    logic          next_servo;

    always_comb begin
        next_state   = state;
        next_aux_num = aux_num;
        next_servo   = servo_on;
        case (state)
            PMJ_MON_NUM: begin
                if (long_mode) begin
                    next_state = PMJ_AUX_NUM;
                end else if (p_set) begin
                    next_state = PMJ_MON_A_LO;
                end
            end
            PMJ_MON_A_LO: begin
                if (p_set) begin
                    next_state = PMJ_MON_NUM;
                end else if (p_up || p_down) begin
                    next_state = PMJ_MON_B_LO;
                end
            end
            PMJ_MON_B_LO: begin
                if (p_set) begin
                    next_state = PMJ_MON_NUM;
                end else if (p_shift) begin
                    next_state = PMJ_MON_B_HI;
                end else if (p_up || p_down) begin
                    next_state = PMJ_MON_A_LO;
                end
            end
            PMJ_MON_B_HI: begin
                if (p_set) begin
                    next_state = PMJ_MON_NUM;
                end else if (p_shift) begin
                    next_state = PMJ_MON_B_LO;
                end
            end
            PMJ_AUX_NUM: begin
                if (long_mode) begin
                    next_state = PMJ_MON_NUM;
                end else if (p_set && aux_num == JOG_AUX_CODE) begin
                    next_state = PMJ_JOG;
                    next_servo = 1'b0;
                end else if (p_up && aux_num != AUX_NUM_MAX) begin
                    next_aux_num = aux_num + 8'h01;
                end else if (p_down && aux_num != 8'h00) begin
                    next_aux_num = aux_num - 8'h01;
                end
            end
            PMJ_JOG: begin
                if (p_set) begin
                    next_state = PMJ_AUX_NUM;
                    next_servo = 1'b0;
                end else if (p_mode) begin
                    next_servo = !servo_on;
                end
            end
            default: begin
                next_state = PMJ_MON_NUM;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= PMJ_MON_NUM;
            aux_num  <= AUX_NUM_RESET;
            servo_on <= 1'b0;
            keys_d   <= 5'h00;
        end else begin
            state    <= next_state;
            aux_num  <= next_aux_num;
            servo_on <= next_servo;
            keys_d   <= keys_now;
        end
    end

    // ==========================================================
    // display and drive outputs
    wire in_jog    = state == PMJ_JOG;
    wire show_b    = state == PMJ_MON_B_LO || state == PMJ_MON_B_HI;
    wire show_hi   = state == PMJ_MON_B_HI;
    wire [MON_W-1:0] mon_sel = show_b ? monitor_b : monitor_a;
    // speed parameter is read live each cycle, so a change needs no restart
    wire [12:0] spd = clamp_speed(jog_speed_param);
    wire run_fwd = in_jog && servo_on && key_up && !key_down;
    wire run_rev = in_jog && servo_on && key_down && !key_up;
    logic signed [13:0] next_speed;

    always_comb begin
        if (run_fwd) begin
            next_speed = $signed({1'b0, spd});
        end else if (run_rev) begin
            next_speed = -$signed({1'b0, spd});
        end else begin
            next_speed = 14'sh0000;
        end
    end

    pmj_show_type next_kind;
    always_comb begin
        case (state)
            PMJ_MON_NUM:  next_kind = PMJ_SHOW_NUM;
            PMJ_AUX_NUM:  next_kind = PMJ_SHOW_AUX;
            PMJ_JOG:      next_kind = PMJ_SHOW_JOG;
            default:      next_kind = PMJ_SHOW_VALUE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            disp_value      <= 16'h0000;
            disp_dp         <= 4'h0;
            disp_kind       <= PMJ_SHOW_NUM;
            disp_number     <= MON_NUM_RESET;
            jog_active      <= 1'b0;
            speed_cmd       <= 14'sh0000;
            position_mode   <= 1'b0;
            fwd_inhibit_eff <= 1'b0;
            rev_inhibit_eff <= 1'b0;
        end else begin
            disp_value      <= half_of(mon_sel, show_hi);
            disp_dp         <= {3'h0, show_b};
            disp_kind       <= next_kind;
            disp_number     <= (state == PMJ_MON_NUM) ? MON_NUM_RESET : aux_num;
            jog_active      <= in_jog;
            speed_cmd       <= next_speed;
            position_mode   <= control_mode_param[CTRL_DIGIT_LSB];
            fwd_inhibit_eff <= forward_drive_inhibit && !in_jog;
            rev_inhibit_eff <= reverse_drive_inhibit && !in_jog;
        end
    end

    // ==========================================================
    // checks
    sequence s_jog_toggle;
        in_jog && p_mode && !p_set;
    endsequence

    // the state moves first and the display follows one edge later
    sequence s_axis_b_low_shown;
        state == PMJ_MON_B_LO ##1 disp_dp[0];
    endsequence

    sequence s_jog_screen_shown;
        in_jog && !servo_on ##1 disp_kind == PMJ_SHOW_JOG;
    endsequence

    AST_A_LOW: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_MON_A_LO |=> disp_value == $past(monitor_a[15:0]) && disp_dp[0] == 1'b0)
        else $error("axis A low half not shown");
    AST_B_LOW: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_MON_A_LO && !p_set && (p_up || p_down) |=> s_axis_b_low_shown)
        else $error("up/down did not select axis B");
    AST_B_HIGH: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_MON_B_HI |=> disp_value == $past(monitor_b[31:16]) && disp_dp[0])
        else $error("axis B high half not shown");
    AST_SET_BACK: assert property (@(posedge clk) disable iff (rst)
        show_b && p_set |=> state == PMJ_MON_NUM)
        else $error("set did not return to monitor number");
    AST_JOG_START: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_AUX_NUM && !long_mode && p_set && aux_num == JOG_AUX_CODE
        |=> s_jog_screen_shown)
        else $error("jog did not start");
    AST_SERVO_TOGGLE: assert property (@(posedge clk) disable iff (rst)
        s_jog_toggle |=> servo_on != $past(servo_on))
        else $error("mode key did not toggle servo");
    AST_JOG_DIR: assert property (@(posedge clk) disable iff (rst)
        run_fwd |=> speed_cmd > 0 || $past(spd) == 13'h0000)
        else $error("up did not run positive");
    AST_JOG_REV: assert property (@(posedge clk) disable iff (rst)
        run_rev |=> speed_cmd < 0 || $past(spd) == 13'h0000)
        else $error("down did not run negative");
    AST_LONG_AUX: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_MON_NUM && long_mode |=> state == PMJ_AUX_NUM)
        else $error("long mode press did not enter aux mode");
    AST_AUX_UP: assert property (@(posedge clk) disable iff (rst)
        state == PMJ_AUX_NUM && !long_mode && !p_set && p_up && aux_num != AUX_NUM_MAX
        |=> aux_num == $past(aux_num) + 8'h01)
        else $error("up did not step the aux number");
    AST_CTRL_MODE: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> position_mode == $past(control_mode_param[CTRL_DIGIT_LSB]))
        else $error("control mode digit not followed");
    AST_JOG_END: assert property (@(posedge clk) disable iff (rst)
        in_jog && p_set |=> state == PMJ_AUX_NUM && aux_num == JOG_AUX_CODE && !servo_on)
        else $error("set did not end jog");
    AST_NO_INHIBIT: assert property (@(posedge clk) disable iff (rst)
        in_jog |=> !fwd_inhibit_eff && !rev_inhibit_eff)
        else $error("inhibit honoured in jog");
    AST_SPEED_CAP: assert property (@(posedge clk) disable iff (rst)
        speed_cmd <= 14'sd6000 && speed_cmd >= -14'sd6000)
        else $error("jog speed out of range");
endmodule

// ==== pmj_pkg.sv ====
package pmj_pkg;
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          HOLD_MS          = 1000;
    localparam int          HOLD_CYCLES      = CLK_HZ / 1000 * HOLD_MS;
    localparam int          MON_W            = 32;
    localparam int          HALF_W           = 16;
    localparam logic [7:0]  MON_NUM_RESET    = 8'h0A;
    localparam logic [7:0]  AUX_NUM_RESET    = 8'h00;
    localparam logic [7:0]  JOG_AUX_CODE     = 8'h02;
    localparam logic [7:0]  AUX_NUM_MAX      = 8'hFF;
    localparam logic [12:0] JOG_SPEED_MAX    = 13'h1770;
    localparam logic [12:0] JOG_SPEED_RESET  = 13'h01F4;
    localparam logic [3:0]  CTRL_MODE_RESET  = 4'h0;
    localparam int          CTRL_DIGIT_LSB   = 4;
    localparam int          DP_BIT           = 0;

    typedef enum logic [2:0] {
        PMJ_MON_NUM,
        PMJ_MON_A_LO,
        PMJ_MON_B_LO,
        PMJ_MON_B_HI,
        PMJ_AUX_NUM,
        PMJ_JOG
    } pmj_state_type;

    typedef enum logic [1:0] {
        PMJ_SHOW_NUM,
        PMJ_SHOW_VALUE,
        PMJ_SHOW_AUX,
        PMJ_SHOW_JOG
    } pmj_show_type;
endpackage

// ==== pmj_hold_timer.sv ====
`timescale 1ns/1ns
module pmj_hold_timer
    import pmj_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic key_level,
    output logic      long_press
);
    // a hold fires once per press, so keeping the key down never repeats it
    logic [31:0] count;
    logic        fired;
    wire         reached = count >= 32'(HOLD_COUNT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 32'h0;
            fired <= 1'b0;
        end else if (!key_level) begin
            count <= 32'h0;
            fired <= 1'b0;
        end else if (!reached) begin
            count <= count + 32'h1;
        end else begin
            fired <= 1'b1;
        end
    end

    assign long_press = key_level && reached && !fired;
endmodule

// ==== pmj_operator.sv ====
`timescale 1ns/1ns
// ============================================================
// operator at the panel keys
module pmj_operator (
    input  wire logic clk,
    output logic [4:0] keys
);
    // key order: 0 mode, 1 up, 2 down, 3 shift, 4 set
    initial keys = 5'h00;

    // keys move only on the falling edge so the panel samples a settled level
    task automatic hold(input int k);
        @(negedge clk);
        keys[k] = 1'b1;
    endtask

    task automatic release_all();
        @(negedge clk);
        keys = 5'h00;
    endtask

    // starting on a fresh edge keeps the key low for one sample first
    task automatic press(input int k, input int n);
        hold(k);
        repeat (n) @(negedge clk);
        keys = 5'h00;
    endtask
endmodule

// ==== panel_monitor_jog_control_bench.sv ====
`timescale 1ns/1ns
module panel_monitor_jog_control_bench
    import pmj_pkg::*;
;
    localparam int HOLD = 20;

    logic               clk     = 1'b0;
    logic               rst     = 1'b1;
    logic [4:0]         keys;
    logic [MON_W-1:0]   mon_a   = 32'h1234ABCD;
    logic [MON_W-1:0]   mon_b   = 32'h5678EF01;
    logic [12:0]        speed_p = 13'h01F4;
    logic [7:0]         ctrl_p  = 8'h00;
    logic               fwd_inh = 1'b1;
    logic               rev_inh = 1'b1;
    logic [HALF_W-1:0]  disp_value;
    logic [3:0]         disp_dp;
    pmj_show_type       disp_kind;
    logic [7:0]         disp_number;
    logic               jog_active;
    logic               servo_on;
    logic signed [13:0] speed_cmd;
    logic               position_mode;
    logic               fwd_eff;
    logic               rev_eff;
    int                 num_errors  = 0;
    int                 check_count = 0;

    always #20 clk = ~clk;

    pmj_operator op (.clk(clk), .keys(keys));

    // short hold count keeps the long mode press to a few dozen cycles
    pmj_panel #(.HOLD_COUNT(HOLD)) uut (
        .clk(clk), .rst(rst),
        .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
        .key_shift(keys[3]), .key_set(keys[4]),
        .monitor_a(mon_a), .monitor_b(mon_b),
        .jog_speed_param(speed_p), .control_mode_param(ctrl_p),
        .forward_drive_inhibit(fwd_inh), .reverse_drive_inhibit(rev_inh),
        .disp_value(disp_value), .disp_dp(disp_dp), .disp_kind(disp_kind),
        .disp_number(disp_number), .jog_active(jog_active), .servo_on(servo_on),
        .speed_cmd(speed_cmd), .position_mode(position_mode),
        .fwd_inhibit_eff(fwd_eff), .rev_inhibit_eff(rev_eff)
    );

    // ============================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // state takes one edge and the display one more
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic test_ctrl();
        ctrl_p = 8'h10;
        settle();
        check(32'(position_mode), 32'h1);
        ctrl_p = 8'h00;
        settle();
        check(32'(position_mode), 32'h0);
    endtask

    task automatic test_monitor();
        check(32'(fwd_eff), 32'h1);
        op.press(4, 1);
        settle();
        check(32'(disp_kind), 32'h1);
        check(32'(disp_value), 32'h0000ABCD);
        check(32'(disp_dp[0]), 32'h0);
        op.press(1, 1);
        settle();
        check(32'(disp_value), 32'h0000EF01);
        check(32'(disp_dp[0]), 32'h1);
        op.press(3, 1);
        settle();
        check(32'(disp_value), 32'h00005678);
        check(32'(disp_dp[0]), 32'h1);
        op.press(4, 1);
        settle();
        check(32'(disp_kind), 32'h0);
        op.press(4, 1);
        op.press(2, 1);
        settle();
        check(32'(disp_value), 32'h0000EF01);
        op.press(3, 1);
        op.press(3, 1);
        settle();
        check(32'(disp_value), 32'h0000EF01);
        op.press(1, 1);
        settle();
        check(32'(disp_value), 32'h0000ABCD);
        check(32'(disp_dp[0]), 32'h0);
        op.press(4, 1);
        settle();
        check(32'(disp_kind), 32'h0);
    endtask

    task automatic test_jog();
        op.press(0, HOLD + 4);
        settle();
        check(32'(disp_kind), 32'h2);
        for (int i = 0; i < 3; i++) begin
            op.press(1, 1);
        end
        op.press(2, 1);
        settle();
        check(32'(disp_number), 32'h2);
        op.press(4, 1);
        settle();
        check(32'(disp_kind), 32'h3);
        check(32'(jog_active), 32'h1);
        check(32'(fwd_eff), 32'h0);
        check(32'(rev_eff), 32'h0);
        op.press(0, 1);
        settle();
        check(32'(servo_on), 32'h1);
        op.hold(1);
        settle();
        check(32'(speed_cmd), 32'h000001F4);
        speed_p = 13'h1B58;
        settle();
        check(32'(speed_cmd), 32'h00001770);
        op.release_all();
        settle();
        check(32'(speed_cmd), 32'h0);
        op.hold(2);
        settle();
        check(32'(speed_cmd), 32'hFFFFE890);
        op.release_all();
        op.press(0, 1);
        settle();
        check(32'(servo_on), 32'h0);
        op.press(4, 1);
        settle();
        check(32'(disp_kind), 32'h2);
        check(32'(disp_number), 32'h2);
        check(32'(jog_active), 32'h0);
    endtask

    // down stops at zero and set away from the jog code is ignored
    task automatic test_refuse();
        check(32'(rev_eff), 32'h1);
        op.press(2, 1);
        op.press(2, 1);
        op.press(2, 1);
        settle();
        check(32'(disp_number), 32'h0);
        op.press(4, 1);
        settle();
        check(32'(jog_active), 32'h0);
        check(32'(disp_kind), 32'h2);
        op.press(0, HOLD + 4);
        settle();
        check(32'(disp_kind), 32'h0);
        check(32'(disp_number), 32'(MON_NUM_RESET));
    endtask

    // a mid-run reset must drop the axis B view back to the monitor number
    task automatic test_reset();
        op.press(4, 1);
        op.press(1, 1);
        settle();
        check(32'(disp_dp[0]), 32'h1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check(32'(disp_kind), 32'h0);
        check(32'(disp_dp), 32'h0);
        check(32'(disp_number), 32'(MON_NUM_RESET));
        rst = 1'b0;
        op.press(4, 1);
        settle();
        check(32'(disp_value), 32'h0000ABCD);
        check(32'(disp_dp[0]), 32'h0);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        settle();
        test_ctrl();
        test_monitor();
        test_jog();
        test_refuse();
        test_reset();
        finish_test();
    end

    // the whole run needs under two hundred cycles
    initial begin
        repeat (5000) @(negedge clk);
        num_errors++;
        finish_test();
    end
endmodule
